// [srgc_top.v]
// Purpose: Reset control and general configuration registers.
// Assumes: Byte register port from the serial control bus slave.
// Notes:   Other registers of the device are held elsewhere; this block
//          drives their restore strobes.
`timescale 1ns/10ps
`include "srgc_regs.vh"
module srgc_top #(
    parameter PULSE_CYC = `SRGC_RST_PULSE_CYC  // Reset pulse length
) (
    input  wire       clk_sys_i,        // System clock, 10 MHz
    input  wire       rst_b_i,          // Async reset, active low
    input  wire       reg_wr_i,         // Register write strobe
    input  wire       reg_rd_i,         // Register read strobe
    input  wire [7:0] reg_addr_i,       // Register offset
    input  wire [7:0] reg_wdata_i,      // Write data
    input  wire [6:0] strap_id_i,       // Address strap level
    input  wire       port_sel_i,       // Second-port select
    input  wire       remote_ack_i,     // Remote acknowledge seen
    input  wire       remote_nack_i,    // Remote not-acknowledge seen
    input  wire       remote_done_i,    // Remote write finished
    input  wire       fwd_req_i,        // Local write aimed at remote
    input  wire       alias_hit_i,      // Target matches alias table
    input  wire       tmds_clk_ok_i,    // Pin: TMDS clock present
    input  wire       data_enable_in_i, // Pin: data enable
    input  wire       horizontal_sync_in_i, // Pin: horizontal sync
    input  wire       vertical_sync_in_i,   // Pin: vertical sync
    output reg  [7:0] reg_rdata_o,      // Read data
    output reg        full_rst_o,       // Full digital reset pulse
    output reg        logic_rst_o,      // Logic-only reset pulse
    output reg        video_rst_o,      // Video-input reset pulse
    output reg        restore_o,        // Restore listed defaults
    output reg        crc_en_o,         // Back-channel CRC checker on
    output reg  [1:0] auto_ack_o,       // Auto-acknowledge per port
    output reg  [1:0] pass_thru_o,      // Pass-through per port
    output reg        local_ack_o,      // Ack to local master
    output reg        local_nack_o,     // Nack to local master
    output reg        fwd_o,            // Forward to remote
    output reg        osc_sel_o,        // Clocking from internal osc
    output reg  [6:0] dev_id_o,         // Device address in use
    output reg        data_enable_o,    // Filtered data enable
    output reg        horizontal_sync_o,// Filtered horizontal sync
    output reg        vertical_sync_o   // Filtered vertical sync
);
    reg  [7:0] cfg_r;
    reg  [6:0] id_r;
    reg        id_set_r;
    reg  [6:0] strap_r;
    reg        strap_done_r;
    reg  [3:0] full_cnt_r;
    reg  [3:0] logic_cnt_r;
    reg  [3:0] video_cnt_r;
    reg  [1:0] aa_r;
    reg  [1:0] pt_r;
    wire       clk_ok_s;
    wire       de_s;
    wire       hs_s;
    wire       vs_s;
    wire       de_f;
    wire       hs_f;
    wire       vs_f;
    wire       lrst;
    wire [3:0] pulse_w;
    wire       wr_rst;
    wire       wr_cfg;
    wire       wr_id;

    assign pulse_w = PULSE_CYC[3:0];
    assign wr_rst  = reg_wr_i && reg_addr_i == `SRGC_ADDR_RESET_CTL;
    assign wr_cfg  = reg_wr_i && reg_addr_i == `SRGC_ADDR_GEN_CFG;
    assign wr_id   = reg_wr_i && reg_addr_i == `SRGC_ADDR_DEVICE_ID;
    assign lrst    = logic_cnt_r != 4'h0;

    //------------------------------------------------------------------
    // Pin synchronisers and timing-line filters
    //------------------------------------------------------------------
    srgc_sync u_sync_clk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .pin_i(tmds_clk_ok_i), .level_o(clk_ok_s));
    srgc_sync u_sync_de (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .pin_i(data_enable_in_i), .level_o(de_s));
    srgc_sync u_sync_hs (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .pin_i(horizontal_sync_in_i), .level_o(hs_s));
    srgc_sync u_sync_vs (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .pin_i(vertical_sync_in_i), .level_o(vs_s));

    srgc_glitch u_flt_de (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .logic_rst_i(lrst),
        .en_i(cfg_r[`SRGC_CFG_FILTER_BIT]), .sig_i(de_s),
        .sig_o(de_f)); // see R09
    srgc_glitch u_flt_hs (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .logic_rst_i(lrst),
        .en_i(cfg_r[`SRGC_CFG_FILTER_BIT]), .sig_i(hs_s),
        .sig_o(hs_f)); // see R09
    srgc_glitch u_flt_vs (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .logic_rst_i(lrst),
        .en_i(cfg_r[`SRGC_CFG_FILTER_BIT]), .sig_i(vs_s),
        .sig_o(vs_f)); // see R09

    //------------------------------------------------------------------
    // Strap capture after reset release; kept for later reloads
    //------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_r      <= 7'h00;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_r      <= strap_id_i;
            strap_done_r <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // Self-clearing reset counters; bits read one while counting
    //------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            full_cnt_r  <= 4'h0;
            logic_cnt_r <= 4'h0;
            video_cnt_r <= 4'h0;
        end else begin
            if (wr_rst && reg_wdata_i[`SRGC_RST_FULL_BIT]) begin
                full_cnt_r <= pulse_w;                // see R01
            end else if (full_cnt_r != 4'h0) begin
                full_cnt_r <= full_cnt_r - 4'h1;      // see R14
            end
            if (wr_rst && reg_wdata_i[`SRGC_RST_LOGIC_BIT]) begin
                logic_cnt_r <= pulse_w;               // see R03
            end else if (logic_cnt_r != 4'h0) begin
                logic_cnt_r <= logic_cnt_r - 4'h1;    // see R14
            end
            if (wr_rst && reg_wdata_i[`SRGC_RST_VIDEO_BIT]) begin
                video_cnt_r <= pulse_w;               // see R13
            end else if (video_cnt_r != 4'h0) begin
                video_cnt_r <= video_cnt_r - 4'h1;
            end
        end
    end

    //------------------------------------------------------------------
    // Register bank; full reset returns everything to defaults, the
    // logic-only reset touches only the address register here
    //------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_r       <= `SRGC_GEN_CFG_RST;
            id_r        <= 7'h00;
            id_set_r    <= `SRGC_ID_SET_RST;
        end else if (full_cnt_r != 4'h0) begin
            cfg_r       <= `SRGC_GEN_CFG_RST;         // see R01
            id_r        <= strap_r;
            id_set_r    <= `SRGC_ID_SET_RST;
        end else if (lrst) begin
            id_r     <= strap_r;                      // see R04
            id_set_r <= `SRGC_ID_SET_RST;             // see R05
        end else begin
            if (!strap_done_r) begin
                id_r <= strap_id_i;
            end
            if (wr_cfg) begin
                cfg_r <= (reg_wdata_i & `SRGC_CFG_WMASK);
            end
            if (wr_id) begin
                id_r     <= reg_wdata_i[7:1];
                id_set_r <= reg_wdata_i[0];
            end
        end
    end

    //------------------------------------------------------------------
    // Port steering of auto-ack and pass-through bits
    //------------------------------------------------------------------
    always @* begin
        aa_r = 2'h0;
        pt_r = 2'h0;
        aa_r[port_sel_i] = cfg_r[`SRGC_CFG_AUTOACK_BIT]; // see R11
        pt_r[port_sel_i] = cfg_r[`SRGC_CFG_PASS_BIT];    // see R11
    end

    //------------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o       <= 8'h00;
            full_rst_o        <= 1'b0;
            logic_rst_o       <= 1'b0;
            video_rst_o       <= 1'b0;
            restore_o         <= 1'b0;
            crc_en_o          <= 1'b0;
            auto_ack_o        <= 2'h0;
            pass_thru_o       <= 2'h0;
            local_ack_o       <= 1'b0;
            local_nack_o      <= 1'b0;
            fwd_o             <= 1'b0;
            osc_sel_o         <= 1'b0;
            dev_id_o          <= 7'h00;
            data_enable_o     <= 1'b0;
            horizontal_sync_o <= 1'b0;
            vertical_sync_o   <= 1'b0;
        end else begin
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `SRGC_ADDR_DEVICE_ID: reg_rdata_o <= {id_r, id_set_r};
                    `SRGC_ADDR_RESET_CTL: reg_rdata_o <= {3'h0,
                        video_cnt_r != 4'h0, 2'h0,
                        full_cnt_r != 4'h0, lrst};       // see R14
                    `SRGC_ADDR_GEN_CFG:   reg_rdata_o <= cfg_r;
                    default:              reg_rdata_o <= 8'h00;
                endcase
            end
            full_rst_o  <= full_cnt_r != 4'h0;
            logic_rst_o <= lrst | (full_cnt_r != 4'h0);   // see R03
            video_rst_o <= video_cnt_r != 4'h0;           // see R13
            restore_o   <= lrst;                          // see R05
            crc_en_o    <= cfg_r[`SRGC_CFG_CRC_BIT];      // see R06
            auto_ack_o  <= aa_r;                          // see R07
            pass_thru_o <= pt_r;                          // see R10
            // Auto-ack answers at once and swallows any remote nack
            local_ack_o <= cfg_r[`SRGC_CFG_AUTOACK_BIT] ? fwd_req_i
                         : (remote_done_i && remote_ack_i); // see R07
            local_nack_o <= !cfg_r[`SRGC_CFG_AUTOACK_BIT]
                         && remote_done_i && remote_nack_i; // see R08
            fwd_o       <= fwd_req_i
                         && cfg_r[`SRGC_CFG_PASS_BIT] && alias_hit_i; // see R10
            osc_sel_o   <= cfg_r[`SRGC_CFG_OSCSW_BIT] && !clk_ok_s; // see R12
            dev_id_o    <= id_set_r ? id_r : strap_r;
            data_enable_o     <= de_f;
            horizontal_sync_o <= hs_f;
            vertical_sync_o   <= vs_f;
        end
    end
endmodule // srgc_top

// [srgc_regs.vh]
// Purpose: Offsets, fields, reset values and timing of the reset and
//          general configuration register logic.
// Assumes: Byte-wide registers on the serial control bus register port.
// Notes:   Included by the top and glitch-filter design files, not the synchroniser.
//
// Overview of operation
// (R01) Full reset bit resets all logic, self-clears; the timing-line filters are cleared only by the logic-only reset, not by it
// (R02) Software then sets bridge-control bit one
// (R03) Logic-only reset spares registers, self-clears
// (R04) Logic-only reset reloads strap-loaded registers
// (R05) Logic-only reset restores listed registers' defaults
// (R06) Bit 7 enables back-channel CRC checker
// (R07) Bit 5 auto-acknowledges remote writes
// (R08) Auto-acknowledge hides remote not-acknowledge
// (R09) Bit 4 filters pulses under two clocks
// (R10) Bit 3 forwards alias-matched transactions
// (R11) Second-port select retargets bits 5 and 3
// (R12) Bit 1 enables oscillator fall-back
// (R13) Reset bit 4 resets video-input block only
// (R14) Self-clearing bit reads one during reset
`ifndef SRGC_REGS_VH
`define SRGC_REGS_VH

//----------------------------------------------------------------------
// Register offsets
//----------------------------------------------------------------------
`define SRGC_ADDR_DEVICE_ID    8'h00
`define SRGC_ADDR_RESET_CTL    8'h01
`define SRGC_ADDR_GEN_CFG      8'h03
`define SRGC_ADDR_BRIDGE_CONTROL_REG   8'h4F

//----------------------------------------------------------------------
// Field positions
//----------------------------------------------------------------------
`define SRGC_RST_LOGIC_BIT     0
`define SRGC_RST_FULL_BIT      1
`define SRGC_RST_VIDEO_BIT     4
`define SRGC_CFG_CRC_BIT       7
`define SRGC_CFG_AUTOACK_BIT   5
`define SRGC_CFG_FILTER_BIT    4
`define SRGC_CFG_PASS_BIT      3
`define SRGC_CFG_OSCSW_BIT     1
`define SRGC_CFG_WMASK         8'hBA
`define SRGC_RST_WMASK         8'h13

//----------------------------------------------------------------------
// Reset values
//----------------------------------------------------------------------
`define SRGC_GEN_CFG_RST       8'hD2
`define SRGC_RESET_CTL_RST     8'h00
`define SRGC_ID_SET_RST        1'h0

//----------------------------------------------------------------------
// Timing
//----------------------------------------------------------------------
`define SRGC_RST_PULSE_CYC     4'h4
`define SRGC_FILT_MIN_CYC      2

`endif

// [srgc_sync.v]
// Purpose: Three-stage synchroniser for a pin-level input.
// Assumes: Input comes from outside the clk_sys_i domain.
// Notes:   A change counts only when stages two and three agree.
`timescale 1ns/10ps
module srgc_sync (
    input  wire clk_sys_i,  // System clock
    input  wire rst_b_i,    // Async reset, active low
    input  wire pin_i,      // Asynchronous input
    output reg  level_o     // Agreed, synchronised level
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    //------------------------------------------------------------------
    // Chain; stage one is read only by stage two
    //------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_o <= s3_r;
            end
        end
    end
endmodule // srgc_sync

// [srgc_glitch.v]
// Purpose: Optional two-clock pulse filter for a video timing line.
// Assumes: Input already synchronous to clk_sys_i.
// Notes:   Adds a fixed latency of one clock when enabled.
`timescale 1ns/10ps
`include "srgc_regs.vh"
module srgc_glitch (
    input  wire clk_sys_i,  // System clock
    input  wire rst_b_i,    // Async reset, active low
    input  wire logic_rst_i,// Logic reset, clears history
    input  wire en_i,       // Filter enable
    input  wire sig_i,      // Synchronised input
    output reg  sig_o       // Filtered output
);
    reg [1:0] cnt_r;

    //------------------------------------------------------------------
    // Output follows a new level only after it holds two clocks
    //------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 2'h0;
            sig_o <= 1'b0;
        end else if (logic_rst_i) begin
            cnt_r <= 2'h0;
            sig_o <= 1'b0;
        end else if (!en_i || sig_i == sig_o) begin
            cnt_r <= 2'h0;
            sig_o <= en_i ? sig_o : sig_i;
        end else if (cnt_r == `SRGC_FILT_MIN_CYC - 1) begin // see R09
            cnt_r <= 2'h0;
            sig_o <= sig_i;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule // srgc_glitch

// [srgc_chk_sva.sv]
// Purpose: Port assertions for the reset and configuration registers.
// Assumes: Writes never land while a reset pulse is counting.
// Notes:   Pulse lengths are counted in helper registers.
`timescale 1ns/10ps
module srgc_chk #(
    parameter PULSE_CYC = 4  // Reset pulse length
) (
    input wire       clk_sys_i,     // System clock
    input wire       rst_b_i,       // Async reset, active low
    input wire       reg_wr_i,      // Write strobe
    input wire [7:0] reg_addr_i,    // Offset
    input wire [7:0] reg_wdata_i,   // Write data
    input wire       port_sel_i,    // Second-port select
    input wire       remote_nack_i, // Remote not-acknowledge
    input wire       remote_done_i, // Remote write finished
    input wire       fwd_req_i,     // Write aimed at remote
    input wire       alias_hit_i,   // Alias table match
    input wire       full_rst_o,    // Full reset pulse
    input wire       logic_rst_o,   // Logic reset pulse
    input wire       restore_o,     // Restore strobe
    input wire       crc_en_o,      // CRC checker on
    input wire [1:0] auto_ack_o,    // Auto-acknowledge per port
    input wire [1:0] pass_thru_o,   // Pass-through per port
    input wire       local_ack_o,   // Ack to local master
    input wire       local_nack_o,  // Nack to local master
    input wire       fwd_o          // Forward to remote
);
    reg [7:0] full_run_r;
    reg [7:0] rest_run_r;
    // Run lengths of both pulses, cleared whenever a pulse is low
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            full_run_r <= 8'h00;
            rest_run_r <= 8'h00;
        end else begin
            full_run_r <= full_rst_o ? full_run_r + 8'h01 : 8'h00;
            rest_run_r <= restore_o ? rest_run_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    chk_full_len: assert property ($fell(full_rst_o) |->
        full_run_r == PULSE_CYC) else $error("full reset length wrong");
    chk_full_cause: assert property ($rose(full_rst_o) |->
        $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
        else $error("full reset without write");
    chk_full_logic: assert property (full_rst_o |-> logic_rst_o
        ) else $error("full reset without logic reset");
    chk_restore_only: assert property (restore_o |->
        logic_rst_o && !full_rst_o) else $error("restore out of place");
    chk_restore_len: assert property ($fell(restore_o) |->
        rest_run_r == PULSE_CYC) else $error("logic reset length wrong");
    chk_crc_follow: assert property (reg_wr_i && reg_addr_i == 8'h03
        && !logic_rst_o |-> ##2 crc_en_o == $past(reg_wdata_i[7], 2))
        else $error("crc enable mismatch");
    chk_auto_ack: assert property (fwd_req_i && auto_ack_o[port_sel_i]
        |=> local_ack_o) else $error("no automatic acknowledge");
    chk_nack_hide: assert property (remote_done_i && remote_nack_i
        && auto_ack_o[port_sel_i] |=> !local_nack_o)
        else $error("remote nack leaked");
    chk_pass_fwd: assert property (fwd_req_i && alias_hit_i
        && pass_thru_o[port_sel_i] |=> fwd_o) else $error("no forward");
endmodule // srgc_chk

bind srgc_top srgc_chk #(.PULSE_CYC(PULSE_CYC)) u_srgc_chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .port_sel_i(port_sel_i), .remote_nack_i(remote_nack_i),
    .remote_done_i(remote_done_i), .fwd_req_i(fwd_req_i),
    .alias_hit_i(alias_hit_i), .full_rst_o(full_rst_o),
    .logic_rst_o(logic_rst_o), .restore_o(restore_o),
    .crc_en_o(crc_en_o), .auto_ack_o(auto_ack_o),
    .pass_thru_o(pass_thru_o), .local_ack_o(local_ack_o),
    .local_nack_o(local_nack_o), .fwd_o(fwd_o));

// [srgc_host.sv]
// Purpose: Host controller model on the register port.
// Assumes: One byte per access, strobes driven at the falling edge.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/10ps
module srgc_host (
    input  wire       clk_sys_i,   // System clock
    input  wire [7:0] reg_rdata_i, // Read data
    output reg        reg_wr_o,    // Write strobe
    output reg        reg_rd_o,    // Read strobe
    output reg  [7:0] reg_addr_o,  // Offset
    output reg  [7:0] reg_wdata_o  // Write data
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'hFF;
        reg_wdata_o = 8'hFF;
    end
    // One-cycle write strobe, then the lines are scrambled
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_sys_i);
            reg_wr_o = 1'b1;
            reg_addr_o = a;
            reg_wdata_o = d;
            @(negedge clk_sys_i);
            reg_wr_o = 1'b0;
            reg_addr_o = ~a;
            reg_wdata_o = ~d;
        end
    endtask
    // Read data is taken one full cycle after the strobe is dropped
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge clk_sys_i);
            reg_rd_o = 1'b1;
            reg_addr_o = a;
            @(negedge clk_sys_i);
            reg_rd_o = 1'b0;
            reg_addr_o = ~a;
            @(negedge clk_sys_i);
            d = reg_rdata_i;
        end
    endtask
    // Full reset, followed by the bridge-control restore write
    task full_reset;
        begin
            wr(8'h01, 8'h02);
            wr(8'h4F, 8'h02);
        end
    endtask
endmodule // srgc_host

// [srgc_top_tb.sv]
// Purpose: Self-checking bench for the reset and configuration block.
// Assumes: Default reset pulse length, strap unchanged after reset.
// Notes:   Random configuration bytes come from an 8-bit LFSR.
`timescale 1ns/10ps
`include "srgc_regs.vh"
module srgc_top_tb;
    reg        clk_sys_i = 1'b0, rst_b_i = 1'b0, port_sel_i = 1'b0;
    reg        remote_ack_i = 1'b0, remote_nack_i = 1'b0;
    reg        remote_done_i = 1'b0, fwd_req_i = 1'b0;
    reg        alias_hit_i = 1'b0, tmds_clk_ok_i = 1'b1;
    reg        de_r = 1'b0, hs_r = 1'b0, vs_r = 1'b0;
    reg  [6:0] strap_id_i = 7'h2A;
    wire       reg_wr_i, reg_rd_i;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire       full_rst_o, logic_rst_o, video_rst_o, restore_o, crc_en_o;
    wire [1:0] auto_ack_o, pass_thru_o;
    wire       local_ack_o, local_nack_o, fwd_o, osc_sel_o;
    wire [6:0] dev_id_o;
    wire       de_o, hs_o, vs_o;
    integer    n_mismatch = 0, n_checks = 0, i, k;
    reg  [7:0] d, s = 8'h1F;
    reg  [2:0] seen;
    always #50 clk_sys_i = ~clk_sys_i;
    srgc_top u_srgc_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .strap_id_i(strap_id_i),
        .port_sel_i(port_sel_i), .remote_ack_i(remote_ack_i),
        .remote_nack_i(remote_nack_i), .remote_done_i(remote_done_i),
        .fwd_req_i(fwd_req_i), .alias_hit_i(alias_hit_i),
        .tmds_clk_ok_i(tmds_clk_ok_i), .data_enable_in_i(de_r),
        .horizontal_sync_in_i(hs_r), .vertical_sync_in_i(vs_r),
        .reg_rdata_o(reg_rdata_o), .full_rst_o(full_rst_o),
        .logic_rst_o(logic_rst_o), .video_rst_o(video_rst_o),
        .restore_o(restore_o), .crc_en_o(crc_en_o),
        .auto_ack_o(auto_ack_o), .pass_thru_o(pass_thru_o),
        .local_ack_o(local_ack_o), .local_nack_o(local_nack_o),
        .fwd_o(fwd_o), .osc_sel_o(osc_sel_o), .dev_id_o(dev_id_o),
        .data_enable_o(de_o), .horizontal_sync_o(hs_o),
        .vertical_sync_o(vs_o));
    srgc_host u_srgc_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i));
    // Next LFSR state, taps 8,6,5,4
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Pulse all three timing pins for n cycles, gather what comes out
    task vpulse(input integer n);
        begin
            seen = 3'b000;
            @(negedge clk_sys_i);
            {de_r, hs_r, vs_r} = 3'b111;
            repeat (n) @(negedge clk_sys_i);
            {de_r, hs_r, vs_r} = 3'b000;
            repeat (12) @(negedge clk_sys_i) seen = seen | {de_o, hs_o, vs_o};
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #(100 * 20000);
        n_mismatch = n_mismatch + 1;
        conclude;
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i) rst_b_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        u_srgc_host.rd(8'h03, d); chk(d, `SRGC_GEN_CFG_RST);
        u_srgc_host.rd(8'h01, d); chk(d, 8'h00);
        u_srgc_host.rd(8'h02, d); chk(d, 8'h00);
        chk({1'b0, dev_id_o}, 8'h2A);
        for (i = 0; i < 8; i = i + 1) begin
            s = lfsr(s);
            u_srgc_host.wr(8'h03, s);
            u_srgc_host.rd(8'h03, d); chk(d, s & `SRGC_CFG_WMASK);
            chk({7'h00, crc_en_o}, {7'h00, s[7]});
        end
        // Auto-acknowledge and nack hiding, both ports, on and off
        for (i = 0; i < 4; i = i + 1) begin
            port_sel_i = i[0];
            u_srgc_host.wr(8'h03, i[1] ? 8'h28 : 8'h00);
            repeat (3) @(negedge clk_sys_i);
            k = {pass_thru_o[i[0]], auto_ack_o[i[0]]};
            chk(k[7:0], {6'h00, i[1], i[1]});
            {fwd_req_i, alias_hit_i} = 2'b11;
            @(negedge clk_sys_i) {fwd_req_i, alias_hit_i} = 2'b00;
            k = {fwd_o, local_ack_o};
            @(negedge clk_sys_i) k = k | {fwd_o, local_ack_o};
            chk(k[7:0], {6'h00, i[1], i[1]});
            {remote_done_i, remote_nack_i} = 2'b11;
            @(negedge clk_sys_i) {remote_done_i, remote_nack_i} = 2'b00;
            k = local_nack_o;
            @(negedge clk_sys_i) k = k | local_nack_o;
            chk(k[7:0], {7'h00, ~i[1]});
        end
        u_srgc_host.wr(8'h03, 8'h10);
        vpulse(1); chk({5'h00, seen}, 8'h00);
        vpulse(2); chk({5'h00, seen}, 8'h07);
        u_srgc_host.wr(8'h03, 8'h00);
        vpulse(2); chk({5'h00, seen}, 8'h07);
        // Oscillator fall-back enabled, then disabled
        u_srgc_host.wr(8'h03, 8'h02);
        tmds_clk_ok_i = 1'b0;
        repeat (10) @(negedge clk_sys_i);
        chk({7'h00, osc_sel_o}, 8'h01);
        u_srgc_host.wr(8'h03, 8'h00);
        repeat (10) @(negedge clk_sys_i);
        chk({7'h00, osc_sel_o}, 8'h00);
        tmds_clk_ok_i = 1'b1;
        // Logic-only reset keeps config, restores address register
        u_srgc_host.wr(8'h00, 8'h23);
        u_srgc_host.wr(8'h03, 8'h38);
        repeat (3) @(negedge clk_sys_i);
        chk({1'b0, dev_id_o}, 8'h11);
        u_srgc_host.wr(8'h01, 8'h01);
        u_srgc_host.rd(8'h01, d); chk(d, 8'h01);
        seen = 3'b000;
        repeat (8) @(negedge clk_sys_i)
            seen = seen | {full_rst_o, restore_o, logic_rst_o};
        chk({5'h00, seen}, 8'h03);
        u_srgc_host.rd(8'h01, d); chk(d, 8'h00);
        u_srgc_host.rd(8'h03, d); chk(d, 8'h38);
        u_srgc_host.rd(8'h00, d); chk(d, 8'h54);
        chk({1'b0, dev_id_o}, 8'h2A);
        u_srgc_host.full_reset;
        seen = 3'b000;
        repeat (8) @(negedge clk_sys_i)
            seen = seen | {full_rst_o, restore_o, logic_rst_o};
        chk({5'h00, seen}, 8'h05);
        u_srgc_host.rd(8'h03, d); chk(d, `SRGC_GEN_CFG_RST);
        u_srgc_host.rd(8'h01, d); chk(d, 8'h00);
        // Video-input reset pulses alone
        u_srgc_host.wr(8'h01, 8'h10);
        seen = 3'b000;
        repeat (6) @(negedge clk_sys_i) seen = seen | {video_rst_o, logic_rst_o, 1'b0};
        chk({5'h00, seen}, 8'h04);
        u_srgc_host.rd(8'h01, d); chk(d, 8'h00);
        conclude;
    end
endmodule // srgc_top_tb
